// file: hdl/prs_pkg.sv
// Purpose: constants for the port register space (offsets, resets, masks)
// Assumes: registers sit one per aligned 32-bit APB word, byte address = index * 4
// Notes:   indices are the printed word offsets of the register window
package prs_pkg;

  // ------------------------------------------------------------
  // window and widths
  // ------------------------------------------------------------
  localparam int unsigned NPORT      = 8;
  localparam int unsigned PIN_W      = 8;
  localparam int unsigned IDX_W      = 7;             // 128-entry window
  localparam logic [6:0]  WIN_FIRST  = 7'h00;         // window start index
  localparam logic [6:0]  WIN_LAST   = 7'h7F;         // window end index

  // ------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------
  localparam logic [6:0] OFS_PORT0_DATA  = 7'h00;
  localparam logic [6:0] OFS_PORT1_DATA  = 7'h01;
  localparam logic [6:0] OFS_PORT0_DIR   = 7'h02;
  localparam logic [6:0] OFS_PORT1_DIR   = 7'h04;
  localparam logic [6:0] OFS_PORT1_FSEL  = 7'h05;
  localparam logic [6:0] OFS_PORT2_DATA  = 7'h06;
  localparam logic [6:0] OFS_PORT3_DATA  = 7'h07;
  localparam logic [6:0] OFS_PORT2_DIR   = 7'h08;
  localparam logic [6:0] OFS_PORT2_FSEL  = 7'h09;
  localparam logic [6:0] OFS_PORT3_DIR   = 7'h0A;
  localparam logic [6:0] OFS_PORT3_FSEL  = 7'h0B;
  localparam logic [6:0] OFS_PORT4_DATA  = 7'h0C;
  localparam logic [6:0] OFS_PORT5_INPUT = 7'h0D;
  localparam logic [6:0] OFS_PORT4_DIR   = 7'h0E;
  localparam logic [6:0] OFS_PORT4_FSEL  = 7'h10;
  localparam logic [6:0] OFS_PORT6_DATA  = 7'h12;
  localparam logic [6:0] OFS_PORT7_DATA  = 7'h13;
  localparam logic [6:0] OFS_PORT6_DIR   = 7'h14;
  localparam logic [6:0] OFS_PORT7_DIR   = 7'h15;
  localparam logic [6:0] OFS_PORT6_FSEL  = 7'h16;

  // ------------------------------------------------------------
  // reset values and fixed pin roles
  // ------------------------------------------------------------
  localparam logic [7:0] DATA_RST [NPORT] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF};
  localparam logic [7:0] DIR_RST         = 8'h00;     // every direction bit an input
  localparam logic [7:0] FSEL_RST        = 8'h00;     // every pin on its latch
  // pins that always drive (port 3 bits 0 and 1 are output only)
  localparam logic [7:0] FORCE_OUT [NPORT] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam int unsigned STROBE_PORT = 3;            // read strobe pin port
  localparam int unsigned STROBE_BIT  = 0;            // read strobe pin bit
  localparam int unsigned INPUT_PORT  = 5;            // input only port

  // ------------------------------------------------------------
  // register kinds
  // ------------------------------------------------------------
  typedef enum {
    PRS_NONE,
    PRS_DATA,
    PRS_INPUT,
    PRS_DIR,
    PRS_FSEL
  } prs_kind_t;

endpackage : prs_pkg

// file: hdl/prs_port_cell.sv
// Purpose: one port's output mux and pin drivers
// Assumes: alternate signals come from same-clock logic
// Notes:   enable outputs are active low; both outputs are registered
`timescale 1ns/1ps
module prs_port_cell #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] latch_i,
  input  wire logic [W-1:0] alt_i,
  input  wire logic [W-1:0] fsel_i,
  input  wire logic [W-1:0] drive_i,
  output logic      [W-1:0] pin_out_o,
  output logic      [W-1:0] pin_oe_n_o
);

  initial begin
    if (W < 1) $error("prs_port_cell: W must be at least 1");
  end

  logic [W-1:0] out_q;
  logic [W-1:0] out_d;
  logic [W-1:0] oe_n_q;
  logic [W-1:0] oe_n_d;

  // pin level: alternate signal or latch, enable from drive mask
  always_comb begin
    out_d  = (fsel_i & alt_i) | (~fsel_i & latch_i);
    oe_n_d = ~drive_i;
  end

  // registered pin drivers, released to input at reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      out_q  <= '0;
      oe_n_q <= '1;
    end else begin
      out_q  <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pin_out_o  = out_q;
  assign pin_oe_n_o = oe_n_q;

endmodule : prs_port_cell

// file: hdl/prs_sync.sv
// Purpose: two-flop synchroniser for the pin inputs
// Assumes: inputs are asynchronous to clk_sys_i
// Notes:   stage one feeds stage two only
`timescale 1ns/1ps
module prs_sync #(
  parameter int unsigned WIDTH = 64
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  initial begin
    if (WIDTH < 1) $error("prs_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // next values: shift one stage
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // two stages
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : prs_sync

// file: hdl/prs_top.sv
// Purpose: port register space of the peripheral window, APB slave plus port pins
// Assumes: APB master on clk_sys_i; pins asynchronous; strobe requests on clk_sys_i
// Notes:   register at index n sits at byte address 4*n
//
// How it works
// - registers decode only inside the 128-entry window from index 00h to 7Fh.
// - with the strobe selected on port 3 bit 0 and its latch at 0, internal reads strobe too.
// - with the strobe selected and the latch at 1, only external reads strobe.
// - port 5 is read only, returns pin states and ignores writes.
// - direction and function-select registers take writes and read back as zero.
`timescale 1ns/1ps
module prs_top
  import prs_pkg::*;
#(
  parameter int unsigned PORT_W = PIN_W
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic      [31:0] prdata_o,
  output logic             pslverr_o,
  input  wire logic [63:0] pin_in_i,
  output logic      [63:0] pin_out_o,
  output logic      [63:0] pin_oe_n_o,
  input  wire logic [63:0] alt_out_i,
  input  wire logic        ext_rd_i,
  input  wire logic        int_rd_i
);

  initial begin
    if (PORT_W != PIN_W) $error("prs_top: PORT_W must equal 8");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0]  data_q [NPORT];
  logic [7:0]  data_d [NPORT];
  logic [7:0]  dir_q  [NPORT];
  logic [7:0]  dir_d  [NPORT];
  logic [7:0]  fsel_q [NPORT];
  logic [7:0]  fsel_d [NPORT];
  logic [7:0]  drive  [NPORT];
  logic        pready_q;
  logic        pready_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [63:0] pin_sync;
  logic [63:0] alt_mux;
  logic [6:0]  idx;
  logic        in_window;
  prs_kind_t   kind;
  logic [2:0]  port;
  logic        setup;
  logic        commit;
  logic        strobe_n;

  // ------------------------------------------------------------
  // pin input synchroniser
  // ------------------------------------------------------------
  prs_sync #(.WIDTH(64)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   (pin_in_i),
    .sync_o    (pin_sync)
  );

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  assign idx       = paddr_i[8:2];
  assign in_window = (paddr_i[31:9] == 23'h0) && (paddr_i[1:0] == 2'b00)
                     && (idx >= WIN_FIRST) && (idx <= WIN_LAST);
  assign setup     = psel_i && !penable_i;
  assign commit    = psel_i && penable_i && pready_q;

  // index to register kind and port
  always_comb begin
    kind = PRS_NONE;
    port = 3'd0;
    if (in_window) begin
      case (idx)
        OFS_PORT0_DATA:  begin kind = PRS_DATA;  port = 3'd0; end
        OFS_PORT1_DATA:  begin kind = PRS_DATA;  port = 3'd1; end
        OFS_PORT0_DIR:   begin kind = PRS_DIR;   port = 3'd0; end
        OFS_PORT1_DIR:   begin kind = PRS_DIR;   port = 3'd1; end
        OFS_PORT1_FSEL:  begin kind = PRS_FSEL;  port = 3'd1; end
        OFS_PORT2_DATA:  begin kind = PRS_DATA;  port = 3'd2; end
        OFS_PORT3_DATA:  begin kind = PRS_DATA;  port = 3'd3; end
        OFS_PORT2_DIR:   begin kind = PRS_DIR;   port = 3'd2; end
        OFS_PORT2_FSEL:  begin kind = PRS_FSEL;  port = 3'd2; end
        OFS_PORT3_DIR:   begin kind = PRS_DIR;   port = 3'd3; end
        OFS_PORT3_FSEL:  begin kind = PRS_FSEL;  port = 3'd3; end
        OFS_PORT4_DATA:  begin kind = PRS_DATA;  port = 3'd4; end
        OFS_PORT5_INPUT: begin kind = PRS_INPUT; port = 3'd5; end
        OFS_PORT4_DIR:   begin kind = PRS_DIR;   port = 3'd4; end
        OFS_PORT4_FSEL:  begin kind = PRS_FSEL;  port = 3'd4; end
        OFS_PORT6_DATA:  begin kind = PRS_DATA;  port = 3'd6; end
        OFS_PORT7_DATA:  begin kind = PRS_DATA;  port = 3'd7; end
        OFS_PORT6_DIR:   begin kind = PRS_DIR;   port = 3'd6; end
        OFS_PORT7_DIR:   begin kind = PRS_DIR;   port = 3'd7; end
        OFS_PORT6_FSEL:  begin kind = PRS_FSEL;  port = 3'd6; end
        default:         begin kind = PRS_NONE;  port = 3'd0; end
      endcase
    end
  end

  // ------------------------------------------------------------
  // register writes (full byte lane 0 only)
  // ------------------------------------------------------------
  always_comb begin
    data_d = data_q;
    dir_d  = dir_q;
    fsel_d = fsel_q;
    if (commit && pwrite_i && pstrb_i[0]) begin
      case (kind)
        PRS_DATA: data_d[port] = pwdata_i[7:0];
        PRS_DIR:  dir_d[port]  = pwdata_i[7:0];
        PRS_FSEL: fsel_d[port] = pwdata_i[7:0];
        PRS_INPUT: ;                              // write has no effect
        default: ;
      endcase
    end
  end

  // register bank
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NPORT; i++) begin
        data_q[i] <= DATA_RST[i];
        dir_q[i]  <= DIR_RST;                     // all direction bits start as inputs; port 3 bits 0 and 1 still drive
        fsel_q[i] <= FSEL_RST;
      end
    end else begin
      data_q <= data_d;
      dir_q  <= dir_d;
      fsel_q <= fsel_d;
    end
  end

  // ------------------------------------------------------------
  // pin drive masks and read strobe
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      drive[i] = dir_q[i] | fsel_q[i] | FORCE_OUT[i];
    end
    drive[INPUT_PORT] = 8'h00;                          // input only port
  end

  // strobe low on external reads, and on internal reads while the latch holds 0
  assign strobe_n = !(ext_rd_i || (int_rd_i && !data_q[STROBE_PORT][STROBE_BIT]));

  always_comb begin
    alt_mux = alt_out_i;
    alt_mux[STROBE_PORT*8+STROBE_BIT] = strobe_n;
  end

  // one cell per port
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    prs_port_cell #(.W(PIN_W)) u_cell (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_i),
      .latch_i    (data_q[g]),
      .alt_i      (alt_mux[g*8 +: 8]),
      .fsel_i     (fsel_q[g]),
      .drive_i    (drive[g]),
      .pin_out_o  (pin_out_o[g*8 +: 8]),
      .pin_oe_n_o (pin_oe_n_o[g*8 +: 8])
    );
  end

  // ------------------------------------------------------------
  // APB answer: one access cycle, data registered in setup
  // ------------------------------------------------------------
  always_comb begin
    pready_d  = setup;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;                             // error stands only beside pready
    if (setup) begin
      prdata_d  = 32'h0000_0000;
      pslverr_d = (kind == PRS_NONE);             // unmapped or outside window
      if (!pwrite_i) begin
        case (kind)
          // driven bits read the latch, others the pin
          PRS_DATA:  prdata_d[7:0] = (drive[port] & data_q[port])
                                     | (~drive[port] & pin_sync[{port, 3'b000} +: 8]);
          PRS_INPUT: prdata_d[7:0] = pin_sync[INPUT_PORT*8 +: 8];
          PRS_DIR:   prdata_d[7:0] = 8'h00;
          PRS_FSEL:  prdata_d[7:0] = 8'h00;
          default:   prdata_d[7:0] = 8'h00;
        endcase
      end
    end
  end

  // answer registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pready_o  = pready_q;
  assign prdata_o  = prdata_q;
  assign pslverr_o = pslverr_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_setup_read(logic [6:0] ofs);
    psel_i && !penable_i && !pwrite_i && (paddr_i == {23'h0, ofs, 2'b00});
  endsequence

  sequence s_access_done;
    psel_i && penable_i && pready_o;
  endsequence

  a_window_err_out: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (setup && (paddr_i[31:9] != 23'h0)) |=> (pready_o && pslverr_o))
    else $error("access outside window not refused");

  a_ready_one_cycle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (setup && penable_i == 1'b0) ##1 (psel_i && penable_i) |-> pready_o ##1 !pready_o)
    else $error("access phase not exactly one cycle");

  a_strobe_internal: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (fsel_q[3][0] && !data_q[3][0] && int_rd_i) |=> !pin_out_o[24] && !pin_oe_n_o[24])
    else $error("internal read strobe missing with latch at 0");

  a_strobe_ext_only: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (fsel_q[3][0] && data_q[3][0] && !ext_rd_i) |=> pin_out_o[24])
    else $error("strobe seen on internal access with latch at 1");

  a_input_port_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_setup_read(OFS_PORT5_INPUT) |=> (prdata_o[7:0] == $past(pin_sync[47:40])) && (pin_oe_n_o[47:40] == 8'hFF))
    else $error("port 5 read does not return pin states");

  a_wo_reads_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_setup_read(OFS_PORT0_DIR) or s_setup_read(OFS_PORT3_FSEL)) |=> (prdata_o == 32'h0 && !pslverr_o))
    else $error("write-only register reads back nonzero");

  a_dir_input_hiz: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (dir_q[0] == 8'h00) ##1 (dir_q[0] == 8'h00) |-> (pin_oe_n_o[7:0] == 8'hFF))
    else $error("port 0 pin driven while direction is input");

  a_dir_write_takes: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_access_done and (pwrite_i && pstrb_i[0] && paddr_i == {23'h0, OFS_PORT0_DIR, 2'b00}))
    |=> ##1 (pin_oe_n_o[7:0] == ~$past(pwdata_i[7:0], 2)))
    else $error("direction write not reflected on pin enables");

  a_fsel_route: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (fsel_q[1][0]) |=> (pin_out_o[8] == $past(alt_out_i[8])) && !pin_oe_n_o[8])
    else $error("alternate signal not routed on port 1 bit 0");

  a_latch_route: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!fsel_q[2][1] && dir_q[2][1]) |=> (pin_out_o[17] == $past(data_q[2][1])))
    else $error("port 2 bit 1 not driven from its latch");

  // ------------------------------------------------------------
  // answer shape, input-only port and external strobe
  // ------------------------------------------------------------
  a_err_needs_ready: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pslverr_o |-> pready_o)
    else $error("error flag without ready");

  a_rdata_low_byte: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pready_o |-> (prdata_o[31:8] == 24'h0))
    else $error("read data above the low byte not zero");

  a_fsel_reads_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_setup_read(OFS_PORT1_FSEL) |=> (prdata_o == 32'h0 && !pslverr_o))
    else $error("function select reads back nonzero");

  a_input_no_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pin_oe_n_o[47:40] == 8'hFF)
    else $error("input-only port driven");

  a_input_wr_ok: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_access_done and (pwrite_i && paddr_i == {23'h0, OFS_PORT5_INPUT, 2'b00}))
    |-> !pslverr_o ##2 $stable(pin_out_o[47:40]))
    else $error("write to input-only port not ignored");

  a_strobe_external: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (fsel_q[3][0] && ext_rd_i) |=> !pin_out_o[24])
    else $error("strobe missing on external access");

endmodule : prs_top

// file: verif/prs_core_model.sv
// Purpose: processor core model, APB master of the register bus
// Assumes: slave answers by pready_i; the bench watchdog ends any hang
// Notes:   a released address or data bus shows its inverse
`timescale 1ns/1ps
module prs_core_model (
  input  wire logic        clk_sys_i,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [31:0] paddr_o,
  output logic      [31:0] pwdata_o,
  output logic      [3:0]  pstrb_o
);
  // idle bus at time zero
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 32'h0;
    pwdata_o  = 32'h0;
    pstrb_o   = 4'h0;
  end

  // one plain transfer: whole byte written, never read-modify-write
  // address comes whole from the caller
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [7:0] data,
                      input logic [3:0] strb, output logic [31:0] rdata, output logic err);
    @(posedge clk_sys_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= addr;
    pwdata_o  <= {24'h0, data};
    pstrb_o   <= strb;
    @(posedge clk_sys_i);
    penable_o <= 1'b1;
    do @(posedge clk_sys_i); while (pready_i !== 1'b1);
    rdata = prdata_i;
    err   = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    paddr_o   <= ~paddr_o;
    pwdata_o  <= ~pwdata_o;
  endtask : xfer
endmodule : prs_core_model

// file: verif/tb.sv
// Purpose: register and pin checks of the port register space
// Assumes: one clock, APB access through the core model
// Notes:   expected values kept in latch, direction and select models
`timescale 1ns/1ps
module tb
  import prs_pkg::*;
;
  logic        clk_sys_i, rst_i, psel, penable, pwrite, pready, pslverr, ext_rd, int_rd;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb;
  logic [63:0] pin_in, pin_out, pin_oe_n, alt_out;
  logic [7:0]  lat [NPORT];
  logic [7:0]  dir_m [NPORT];
  logic [7:0]  fsel_m [NPORT];
  int          error_cnt;
  int          cmp_count;
  logic [31:0] ua_data;
  logic        ua_err;
  localparam int DIR_IDX [NPORT]  = '{OFS_PORT0_DIR, OFS_PORT1_DIR, OFS_PORT2_DIR, OFS_PORT3_DIR,
                                      OFS_PORT4_DIR, 0, OFS_PORT6_DIR, OFS_PORT7_DIR};
  localparam int FSEL_IDX [NPORT] = '{0, OFS_PORT1_FSEL, OFS_PORT2_FSEL, OFS_PORT3_FSEL,
                                      OFS_PORT4_FSEL, 0, OFS_PORT6_FSEL, 0};
  localparam int DATA_IDX [NPORT] = '{OFS_PORT0_DATA, OFS_PORT1_DATA, OFS_PORT2_DATA, OFS_PORT3_DATA,
                                      OFS_PORT4_DATA, OFS_PORT5_INPUT, OFS_PORT6_DATA, OFS_PORT7_DATA};
  localparam int BAD [7]          = '{8'h03, 8'h0F, 8'h11, 8'h17, 8'h7F, 9'h080, 9'h1FF};
  localparam logic [7:0] HAS_FSEL = 8'h5E;
  localparam logic [7:0] ONES [NPORT] = '{8'h00, 8'h00, 8'h00, 8'h18, 8'h01, 8'h00, 8'hC0, 8'hFC};

  prs_core_model u_core (.clk_sys_i(clk_sys_i), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));
  prs_top #(.PORT_W(8)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n),
    .alt_out_i(alt_out), .ext_rd_i(ext_rd), .int_rd_i(int_rd));

  // 100 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // watchdog against a hung transfer
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end

  task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(int idx, logic [7:0] data, logic [3:0] strb = 4'hF, logic err_x = 1'b0);
    logic [31:0] d;
    logic        e;
    u_core.xfer(1'b1, 32'(idx * 4), data, strb, d, e);
    chk($sformatf("write error %h", idx), err_x, e);
  endtask : wr

  task automatic rd(int idx, logic [7:0] exp, logic err_x = 1'b0);
    logic [31:0] d;
    logic        e;
    u_core.xfer(1'b0, 32'(idx * 4), 8'h00, 4'h0, d, e);
    chk($sformatf("read %h", idx), exp, d);
    chk($sformatf("read error %h", idx), err_x, e);
  endtask : rd

  // driven bits read the latch, the others the pins
  function automatic logic [7:0] exp_rd(int p);
    logic [7:0] drv;
    drv = (p == INPUT_PORT) ? 8'h00 : (dir_m[p] | fsel_m[p] | FORCE_OUT[p]);
    return (lat[p] & drv) | (pin_in[p*8 +: 8] & ~drv);
  endfunction : exp_rd

  function automatic logic [7:0] exp_out(int p);
    logic [7:0] o;
    o = (lat[p] & ~fsel_m[p]) | (alt_out[p*8 +: 8] & fsel_m[p]);
    if (p == STROBE_PORT && fsel_m[p][STROBE_BIT]) o[STROBE_BIT] = !(ext_rd | (int_rd & !lat[p][STROBE_BIT]));
    return o;
  endfunction : exp_out

  // enables kept at eight bits so the inversion does not spill into wider compares
  function automatic logic [7:0] exp_oe(int p);
    if (p == INPUT_PORT) return 8'hFF;
    return ~(dir_m[p] | fsel_m[p] | FORCE_OUT[p]);
  endfunction : exp_oe

  task automatic rd_all(string name);
    for (int p = 0; p < NPORT; p++) rd(DATA_IDX[p], exp_rd(p));
    $display("test %s done, mismatches %0d", name, error_cnt);
  endtask : rd_all

  task automatic pins();
    repeat (4) @(posedge clk_sys_i);
    for (int p = 0; p < NPORT; p++) begin
      chk($sformatf("pin_out port %0d", p), exp_out(p), pin_out[p*8 +: 8]);
      chk($sformatf("pin_oe_n port %0d", p), exp_oe(p), pin_oe_n[p*8 +: 8]);
    end
  endtask : pins

  // main sequence
  initial begin
    rst_i = 1'b1;
    pin_in = 64'h5AC3_96E1_0F78_A52D;
    alt_out = 64'hC33C_A55A_0FF0_9669;
    ext_rd = 1'b0;
    int_rd = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    for (int p = 0; p < NPORT; p++) begin
      lat[p] = DATA_RST[p];
      dir_m[p] = DIR_RST;
      fsel_m[p] = FSEL_RST;
    end
    repeat (2) @(posedge clk_sys_i);
    chk("pin_oe_n in reset", 64'hFFFF_FFFF_FFFF_FFFF, pin_oe_n);
    rst_i <= 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      if (p != INPUT_PORT) rd(DIR_IDX[p], 8'h00);
      if (HAS_FSEL[p]) rd(FSEL_IDX[p], 8'h00);
    end
    pins();
    rd_all("reset");
    // latches and directions, must-write-one bits set
    for (int p = 0; p < NPORT; p++) if (p != INPUT_PORT) begin
      lat[p] = 8'h3C ^ 8'(p * 17) | ONES[p];
      dir_m[p] = 8'hA6 | ONES[p];
      wr(DATA_IDX[p], lat[p]);
      wr(DIR_IDX[p], dir_m[p]);
    end
    pins();
    rd_all("direction");
    // alternate functions, port 2 left with direction 0
    dir_m[2] = 8'h00;
    wr(DIR_IDX[2], 8'h00);
    for (int p = 0; p < NPORT; p++) if (HAS_FSEL[p]) begin
      fsel_m[p] = 8'h25;
      wr(FSEL_IDX[p], 8'h25);
      rd(FSEL_IDX[p], 8'h00);
    end
    pins();
    rd_all("function select");
    // read strobe against latch level and access kind
    for (int k = 0; k < 8; k++) begin
      lat[STROBE_PORT][STROBE_BIT] = k[2];
      wr(DATA_IDX[STROBE_PORT], lat[STROBE_PORT]);
      ext_rd <= k[0];
      int_rd <= k[1];
      pins();
    end
    ext_rd <= 1'b0;
    int_rd <= 1'b0;
    $display("test strobe done, mismatches %0d", error_cnt);
    // input-only port ignores writes and follows its pins
    wr(OFS_PORT5_INPUT, 8'hFF);
    rd(OFS_PORT5_INPUT, pin_in[47:40]);
    pin_in <= pin_in ^ 64'h0000_FF00_0000_0000;
    repeat (3) @(posedge clk_sys_i);
    rd(OFS_PORT5_INPUT, pin_in[47:40]);
    $display("test input port done, mismatches %0d", error_cnt);
    // unassigned and outside-window places
    for (int i = 0; i < 7; i++) begin
      rd(BAD[i], 8'h00, 1'b1);
      wr(BAD[i], 8'hFF, 4'hF, 1'b1);
    end
    u_core.xfer(1'b0, 32'h0000_0005, 8'h00, 4'h0, ua_data, ua_err);
    chk("unaligned read error", 1'b1, ua_err);
    chk("unaligned read data", 32'h0, ua_data);
    wr(OFS_PORT1_DATA, ~lat[1], 4'h0);
    rd_all("unmapped");
    test_done();
  end
endmodule : tb
